// ==== core/mlm_consts.vh ====
// Constants for the serial slave and link loss monitor
`ifndef MLM_CONSTS_VH
`define MLM_CONSTS_VH
`define MLM_CLK_NS 10
`define MLM_SEC_NS 1000000000
`define MLM_MON_MIN_S 10'h01e
`define MLM_MON_MAX_S 10'h258
`define MLM_MON_DEF_S 10'h01e
`define MLM_FC_WRITE 8'h06
`define MLM_FC_READ 8'h04
`define MLM_REG_DISP1 16'h0038
`define MLM_REG_SRCSEL 16'h0043
`define MLM_SRCSEL_RST 16'h0000
`define MLM_RD_QTY 16'h0001
`define MLM_RD_BYTES 8'h02
`define MLM_RTU_REQ_LEN 4'h8
`define MLM_ASC_REQ_LEN 4'h7
`define MLM_LEN_OVF 4'h9
`define MLM_WR_RSP_LEN 3'h6
`define MLM_RD_RSP_LEN 3'h5
`define MLM_CRC_INIT 16'hffff
`define MLM_CRC_POLY 16'ha001
`define MLM_CH_COLON 8'h3a
`define MLM_CH_CR 8'h0d
`define MLM_CH_LF 8'h0a
`define MLM_SRC_NONE 4'h0
`define MLM_SRC_AMB 4'h1
`define MLM_SRC_EXT 4'h2
`define MLM_SRC_CH1 4'h3
`define MLM_SRC_MNT 4'h4
`define MLM_SRC_PRS 4'h5
`define MLM_VAL_MIN 16'hf334
`define MLM_VAL_MAX 16'h0ccc
`define MLM_ACT_OFF 2'h0
`define MLM_ACT_WARN 2'h1
`define MLM_ACT_FAULT 2'h2
`endif

// ==== core/mlm_buf.v ====
// Two-entry byte buffer with valid and ready on both sides
module mlm_buf (
    input wire i_sys_clk,
    input wire i_rst,
    input wire [7:0] i_in_data,
    input wire i_in_valid,
    output wire o_in_ready,
    output wire [7:0] o_out_data,
    output wire o_out_valid,
    input wire i_out_ready
);
    reg [7:0] mem_r [0:1]; // Storage slots
    reg wp_r; // Write slot
    reg rp_r; // Read slot
    reg [1:0] cnt_r; // Words held
    reg [7:0] out_r; // Registered head word
    wire push = i_in_valid && o_in_ready;
    wire pop = o_out_valid && i_out_ready;

    assign o_in_ready = (cnt_r != 2'h2);
    assign o_out_valid = (cnt_r != 2'h0);
    assign o_out_data = out_r;

    // Pointer and count bookkeeping
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (push)
                wp_r <= ~wp_r;
            if (pop)
                rp_r <= ~rp_r;
            if (push && !pop)
                cnt_r <= cnt_r + 2'h1;
            else if (pop && !push)
                cnt_r <= cnt_r - 2'h1;
        end
    end

    // Slot writes
    always @(posedge i_sys_clk) begin
        if (push)
            mem_r[wp_r] <= i_in_data;
    end

    // Head word register follows the read slot
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst)
            out_r <= 8'h00;
        else if (push && (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop)))
            out_r <= i_in_data;
        else if (pop && cnt_r == 2'h2)
            out_r <= mem_r[~rp_r];
    end
endmodule

// ==== core/mlm_top.v ====
// Serial slave with write/read handling and link loss supervision
`include "mlm_consts.vh"
//
// Operation
// - Write request answered with identical echo
// - Write reply carries the stored value
// - Read reply puts byte count before data
// - Register 0038h returns selected quantity, high first
// - ASCII: hex pairs, colon, CR/LF, LRC
// - RTU: raw bytes ending in CRC
// - Supervision only in host serial mode
// - Alarm after full monitoring time silent
// - Monitoring time 30 to 600 s, default 30
// - Action off, warn or fault; warn default
// - Alarm clears on next good frame addressed to this slave
// - Writing 0001h to 0043h selects ambient
// - Temperatures signed, 0.1 degree, F334h..0CCCh
module mlm_top #(
    parameter P_SEC_CYC = `MLM_SEC_NS / `MLM_CLK_NS
) (
    input wire i_sys_clk,
    input wire i_rst,
    input wire i_ascii_mode,
    input wire [7:0] i_slave_addr,
    input wire [7:0] i_rx_data,
    input wire i_rx_valid,
    input wire i_rx_eof,
    output wire [7:0] o_tx_data,
    output wire o_tx_valid,
    input wire i_tx_ready,
    input wire i_serial_mode,
    input wire [1:0] i_alarm_action,
    input wire [9:0] i_mon_time_s,
    input wire [15:0] i_ambient_temp,
    input wire [15:0] i_ext_tune_temp,
    input wire [15:0] i_ch1_inlet_temp,
    input wire [15:0] i_maint_notice,
    input wire [15:0] i_hp_pressure,
    output reg [15:0] o_display_source_select,
    output reg [15:0] o_first_display_value,
    output reg o_link_loss_alarm,
    output reg o_warn_keep_running,
    output reg o_fault_halt
);
    // Transmit states
    localparam S_IDLE = 3'h0;
    localparam S_HDR = 3'h1;
    localparam S_BYTE = 3'h2;
    localparam S_CHK = 3'h3;
    localparam S_CR = 3'h4;
    localparam S_LF = 3'h5;

    // One CRC-16 byte step, reflected polynomial
    function [15:0] crc_step;
        input [15:0] crc;
        input [7:0] b;
        reg [15:0] c;
        integer k;
        begin
            c = crc ^ {8'h00, b};
            for (k = 0; k < 8; k = k + 1)
                c = c[0] ? ((c >> 1) ^ `MLM_CRC_POLY) : (c >> 1);
            crc_step = c;
        end
    endfunction
    // Nibble to upper-case hex character
    function [7:0] hex_char;
        input [3:0] n;
        begin
            hex_char = (n < 4'ha) ? (8'h30 + {4'h0, n})
                                  : (8'h37 + {4'h0, n});
        end
    endfunction
    // Hex character to nibble, bit 4 flags a legal character
    function [4:0] hex_val;
        input [7:0] c;
        begin
            hex_val = (c >= 8'h30 && c <= 8'h39) ? {1'b1, c[3:0]} :
                      (c >= 8'h41 && c <= 8'h46) ? {1'b1, c[3:0] + 4'h9} :
                      5'h00;
        end
    endfunction
    // Signed clamp to the displayable temperature span
    function [15:0] clamp_t;
        input [15:0] v;
        begin
            clamp_t = ($signed(v) < $signed(`MLM_VAL_MIN)) ? `MLM_VAL_MIN :
                      ($signed(v) > $signed(`MLM_VAL_MAX)) ? `MLM_VAL_MAX : v;
        end
    endfunction
    // Receive side state
    reg [63:0] rx_sh_r; // Last eight request bytes
    reg [3:0] rx_len_r; // Bytes of this frame
    reg [15:0] rx_crc_r; // Running CRC
    reg [7:0] rx_lrc_r; // Running byte sum
    reg [3:0] rx_hi_r; // First nibble of a pair
    reg rx_half_r; // One nibble pending
    reg rx_in_r; // Inside an ASCII frame
    reg rx_bad_r; // Illegal character seen
    // Transmit side state
    reg [2:0] tx_st_r; // Transmit state
    reg [47:0] rsp_sh_r; // Reply bytes, first at top
    reg [2:0] rsp_left_r; // Reply bytes still to send
    reg tx_nib_r; // Low nibble next in ASCII
    reg tx_ci_r; // Second checksum byte in RTU
    reg [15:0] tx_crc_r; // Reply CRC
    reg [7:0] tx_lrc_r; // Reply LRC, negated byte sum
    reg [7:0] tx_data; // Character offered to buffer
    reg tx_push; // Offer valid
    wire tx_rdy; // Buffer accepts
    wire busy = (tx_st_r != S_IDLE);
    // Decoded receive byte in either framing
    wire [4:0] hv = hex_val(i_rx_data);
    wire asc_byte = i_ascii_mode && rx_in_r && rx_half_r && hv[4];
    wire rtu_byte = !i_ascii_mode && i_rx_valid;
    wire [7:0] in_byte = i_ascii_mode ? {rx_hi_r, hv[3:0]} : i_rx_data;
    wire got_byte = !busy && (rtu_byte || (i_rx_valid && asc_byte));
    wire asc_end = i_ascii_mode && i_rx_valid && rx_in_r &&
                   (i_rx_data == `MLM_CH_LF);
    wire frm_end = !busy && (asc_end || (!i_ascii_mode && i_rx_eof));
    // Request fields, ASCII holds a one-byte checksum tail in the shifter
    wire [63:0] fr = i_ascii_mode ? {rx_sh_r[55:0], 8'h00} : rx_sh_r;
    wire [7:0] f_addr = fr[63:56];
    wire [7:0] f_fc = fr[55:48];
    wire [15:0] f_reg = fr[47:32];
    wire [15:0] f_val = fr[31:16];
    wire len_ok = i_ascii_mode ? (rx_len_r == `MLM_ASC_REQ_LEN)
                               : (rx_len_r == `MLM_RTU_REQ_LEN);
    wire chk_ok = i_ascii_mode ? (rx_lrc_r == 8'h00 && !rx_bad_r)
                               : (rx_crc_r == 16'h0000);
    wire frm_ok = frm_end && len_ok && chk_ok &&
                  (f_addr == i_slave_addr);
    wire do_wr = frm_ok && f_fc == `MLM_FC_WRITE &&
                 f_reg == `MLM_REG_SRCSEL;
    wire do_rd = frm_ok && f_fc == `MLM_FC_READ &&
                 f_reg == `MLM_REG_DISP1 &&
                 f_val == `MLM_RD_QTY;
    // Request collection, checksum and ASCII nibble pairing
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_sh_r <= 64'h0;
            rx_len_r <= 4'h0;
            rx_crc_r <= `MLM_CRC_INIT;
            rx_lrc_r <= 8'h00;
            rx_hi_r <= 4'h0;
            rx_half_r <= 1'b0;
            rx_in_r <= 1'b0;
            rx_bad_r <= 1'b0;
        end else if (frm_end || (i_ascii_mode && i_rx_valid &&
                     i_rx_data == `MLM_CH_COLON)) begin
            // Frame boundary restarts collection; colon opens ASCII
            rx_len_r <= 4'h0;
            rx_crc_r <= `MLM_CRC_INIT;
            rx_lrc_r <= 8'h00;
            rx_half_r <= 1'b0;
            rx_bad_r <= 1'b0;
            rx_in_r <= !frm_end;
        end else if (i_rx_valid && !busy) begin
            if (got_byte) begin
                rx_sh_r <= {rx_sh_r[55:0], in_byte};
                if (rx_len_r != `MLM_LEN_OVF)
                    rx_len_r <= rx_len_r + 4'h1;
                rx_crc_r <= crc_step(rx_crc_r, in_byte);
                rx_lrc_r <= rx_lrc_r + in_byte;
                rx_half_r <= 1'b0;
            end else if (i_ascii_mode && rx_in_r) begin
                // High nibble, CR, or a stray character
                if (hv[4]) begin
                    rx_hi_r <= hv[3:0];
                    rx_half_r <= 1'b1;
                end else if (i_rx_data != `MLM_CH_CR || rx_half_r) begin
                    rx_bad_r <= 1'b1;
                end
            end
        end
    end
    // Source select register and selected display value
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_display_source_select <= `MLM_SRCSEL_RST;
            o_first_display_value <= 16'h0000;
        end else begin
            if (do_wr)
                o_display_source_select <= f_val;
            case (o_display_source_select[3:0])
                `MLM_SRC_AMB: o_first_display_value <=
                    clamp_t(i_ambient_temp);
                `MLM_SRC_EXT: o_first_display_value <=
                    clamp_t(i_ext_tune_temp);
                `MLM_SRC_CH1: o_first_display_value <=
                    clamp_t(i_ch1_inlet_temp);
                `MLM_SRC_MNT: o_first_display_value <= i_maint_notice;
                `MLM_SRC_PRS: o_first_display_value <=
                    clamp_t(i_hp_pressure);
                default: o_first_display_value <= 16'h0000;
            endcase
        end
    end
    // Character offered to the output buffer in each state
    always @* begin
        tx_data = 8'h00;
        tx_push = busy;
        case (tx_st_r)
            S_HDR: tx_data = `MLM_CH_COLON;
            S_BYTE: tx_data = !i_ascii_mode ? rsp_sh_r[47:40] :
                hex_char(tx_nib_r ? rsp_sh_r[43:40] : rsp_sh_r[47:44]);
            S_CHK: tx_data = !i_ascii_mode ?
                (tx_ci_r ? tx_crc_r[15:8] : tx_crc_r[7:0]) :
                hex_char(tx_nib_r ? tx_lrc_r[3:0] : tx_lrc_r[7:4]);
            S_CR: tx_data = `MLM_CH_CR;
            S_LF: tx_data = `MLM_CH_LF;
            default: tx_data = 8'h00;
        endcase
    end
    // Reply sequencer, stalls while the buffer is full
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            tx_st_r <= S_IDLE;
            rsp_sh_r <= 48'h0;
            rsp_left_r <= 3'h0;
            tx_nib_r <= 1'b0;
            tx_ci_r <= 1'b0;
            tx_crc_r <= `MLM_CRC_INIT;
            tx_lrc_r <= 8'h00;
        end else begin
            case (tx_st_r)
                S_IDLE: begin
                    tx_crc_r <= `MLM_CRC_INIT;
                    tx_lrc_r <= 8'h00;
                    if (do_wr) begin
                        // Echo of address, function, register, value
                        rsp_sh_r <= {f_addr, f_fc, f_reg,
                                     f_val};
                        rsp_left_r <= `MLM_WR_RSP_LEN;
                        tx_st_r <= i_ascii_mode ? S_HDR : S_BYTE;
                    end else if (do_rd) begin
                        rsp_sh_r <= {f_addr, f_fc, `MLM_RD_BYTES,
                                     o_first_display_value,
                                     8'h00};
                        rsp_left_r <= `MLM_RD_RSP_LEN;
                        tx_st_r <= i_ascii_mode ? S_HDR : S_BYTE;
                    end
                end
                S_HDR: if (tx_rdy)
                    tx_st_r <= S_BYTE;
                S_BYTE: begin
                    if (tx_rdy) begin
                        if (i_ascii_mode && !tx_nib_r)
                            tx_nib_r <= 1'b1;
                        else begin
                            tx_nib_r <= 1'b0;
                            tx_crc_r <= crc_step(tx_crc_r,
                                                 rsp_sh_r[47:40]);
                            tx_lrc_r <= tx_lrc_r - rsp_sh_r[47:40];
                            rsp_sh_r <= {rsp_sh_r[39:0], 8'h00};
                            rsp_left_r <= rsp_left_r - 3'h1;
                            if (rsp_left_r == 3'h1)
                                tx_st_r <= S_CHK;
                        end
                    end
                end
                S_CHK: begin
                    if (tx_rdy) begin
                        if (i_ascii_mode) begin
                            tx_nib_r <= ~tx_nib_r;
                            if (tx_nib_r)
                                tx_st_r <= S_CR;
                        end else begin
                            tx_ci_r <= ~tx_ci_r;
                            if (tx_ci_r)
                                tx_st_r <= S_IDLE;
                        end
                    end
                end
                S_CR: if (tx_rdy)
                    tx_st_r <= S_LF;
                S_LF: if (tx_rdy)
                    tx_st_r <= S_IDLE;
                default: tx_st_r <= S_IDLE;
            endcase
        end
    end
    // Reply characters pass through the two-entry buffer
    mlm_buf u_buf (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_in_data(tx_data),
        .i_in_valid(tx_push),
        .o_in_ready(tx_rdy),
        .o_out_data(o_tx_data),
        .o_out_valid(o_tx_valid),
        .i_out_ready(i_tx_ready)
    );
    // Monitoring time, clamped to its legal span
    wire [9:0] mon_s = (i_mon_time_s < `MLM_MON_MIN_S) ? `MLM_MON_MIN_S :
                       (i_mon_time_s > `MLM_MON_MAX_S) ? `MLM_MON_MAX_S :
                       i_mon_time_s;
    wire sup_on = i_serial_mode &&
                  i_alarm_action != `MLM_ACT_OFF;
    reg [31:0] tick_r; // Cycles within the current second
    reg [9:0] sec_r; // Whole seconds of silence
    // Link loss watchdog
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            tick_r <= 32'h0;
            sec_r <= 10'h000;
            o_link_loss_alarm <= 1'b0;
            o_warn_keep_running <= 1'b0;
            o_fault_halt <= 1'b0;
        end else begin
            o_fault_halt <= 1'b0;
            if (!sup_on || frm_ok) begin
                // Idle when supervision is off; good frame restarts
                tick_r <= 32'h0;
                sec_r <= 10'h000;
                o_link_loss_alarm <= 1'b0;
                o_warn_keep_running <= 1'b0;
            end else if (sec_r >= mon_s) begin // Silence reached limit
                if (!o_link_loss_alarm) begin
                    o_link_loss_alarm <= 1'b1;
                    o_warn_keep_running <=
                        (i_alarm_action == `MLM_ACT_WARN);
                    o_fault_halt <=
                        (i_alarm_action == `MLM_ACT_FAULT);
                end
            end else if (tick_r == P_SEC_CYC - 1) begin
                tick_r <= 32'h0;
                sec_r <= sec_r + 10'h001;
            end else begin
                tick_r <= tick_r + 32'h1;
            end
        end
    end
endmodule

// ==== tb/mlm_chk_checker.sv ====
// Port checker for the serial slave and link loss monitor
module mlm_chk #(
    parameter P_SEC_CYC = 10
) (
    input wire i_sys_clk,
    input wire i_rst,
    input wire i_serial_mode,
    input wire [1:0] i_alarm_action,
    input wire i_tx_ready,
    input wire [15:0] i_ambient_temp,
    input wire [7:0] o_tx_data,
    input wire o_tx_valid,
    input wire [15:0] o_display_source_select,
    input wire [15:0] o_first_display_value,
    input wire o_link_loss_alarm,
    input wire o_warn_keep_running,
    input wire o_fault_halt
);
    timeunit 1ns;
    timeprecision 1ps;
    int quiet_r; // Cycles since the last reply or supervision pause
    default clocking @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    // A reply proves that a good frame restarted the device timer
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst)
            quiet_r <= 0;
        else if (o_tx_valid || !i_serial_mode || i_alarm_action == 2'h0)
            quiet_r <= 0;
        else
            quiet_r <= quiet_r + 1;
    end
    AST_WARN_ALARM: assert property (
        o_warn_keep_running |-> o_link_loss_alarm)
        else $error("warn flag without alarm");
    AST_HALT_ONSET: assert property (
        o_fault_halt |-> $rose(o_link_loss_alarm) ##1 !o_fault_halt)
        else $error("halt pulse not at alarm onset");
    AST_MODE_OFF: assert property (
        !i_serial_mode |=> !o_link_loss_alarm)
        else $error("alarm outside host serial mode");
    AST_ACTION_OFF: assert property (
        i_alarm_action == 2'h0 |=> !o_link_loss_alarm)
        else $error("alarm with supervision disabled");
    AST_NO_EARLY: assert property (
        $rose(o_link_loss_alarm) |-> quiet_r + 24 >= 30 * P_SEC_CYC)
        else $error("alarm before monitoring time");
    AST_REPLY_CLEARS: assert property (
        $rose(o_tx_valid) |-> !o_link_loss_alarm)
        else $error("alarm still set after good frame");
    AST_TX_HOLDS: assert property (
        o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
        else $error("reply unit lost while stalled");
    AST_DISP_AMB: assert property (
        $past(o_display_source_select[3:0]) == 4'h1
        |-> o_first_display_value == $past(i_ambient_temp))
        else $error("display one does not follow ambient");
    AST_SEL_ECHO: assert property (
        $changed(o_display_source_select) |-> ##[0:4] o_tx_valid)
        else $error("select changed without echo");
endmodule
bind mlm_top mlm_chk #(.P_SEC_CYC(P_SEC_CYC)) u_chk (
    .i_sys_clk, .i_rst, .i_serial_mode, .i_alarm_action, .i_tx_ready,
    .i_ambient_temp, .o_tx_data, .o_tx_valid, .o_display_source_select,
    .o_first_display_value, .o_link_loss_alarm, .o_warn_keep_running,
    .o_fault_halt
);

// ==== tb/mlm_host.sv ====
// Host master model: sends framed requests, takes reply units
`include "mlm_consts.vh"
module mlm_host (
    input wire logic i_sys_clk,
    input wire logic i_stall,
    input wire logic [7:0] i_tx_data,
    input wire logic i_tx_valid,
    output logic [7:0] o_rx_data,
    output logic o_rx_valid,
    output logic o_rx_eof,
    output logic o_tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got_q[$]; // Reply units taken
    logic [7:0] line_q[$]; // Frame last built
    logic [1:0] pace_r = 2'h0; // Paces the taker while stalling
    initial begin
        o_rx_data = 8'h00;
        o_rx_valid = 1'b0;
        o_rx_eof = 1'b0;
        o_tx_ready = 1'b1;
    end
    // Take offered units; while stalling accept one cycle in four
    always @(posedge i_sys_clk) begin
        if (i_tx_valid && o_tx_ready)
            got_q.push_back(i_tx_data);
        pace_r <= pace_r + 2'h1;
        o_tx_ready <= !i_stall || pace_r == 2'h3;
    end
    // Upper-case hex character of a nibble
    function automatic logic [7:0] hexc(input logic [3:0] n);
        return n < 4'ha ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
    endfunction
    // Frame a payload with its checksum, ASCII or binary
    function automatic void frame(input logic asc, input logic [7:0] p[$]);
        logic [15:0] c;
        logic [7:0] s;
        c = `MLM_CRC_INIT;
        s = 8'h00;
        line_q = {};
        if (asc)
            line_q.push_back(`MLM_CH_COLON);
        foreach (p[i]) begin
            s = s + p[i];
            c = c ^ {8'h00, p[i]};
            for (int k = 0; k < 8; k++)
                c = c[0] ? (c >> 1) ^ `MLM_CRC_POLY : c >> 1;
            if (asc)
                line_q = {line_q, hexc(p[i][7:4]), hexc(p[i][3:0])};
            else
                line_q.push_back(p[i]);
        end
        s = 8'h00 - s;
        if (asc)
            line_q = {line_q, hexc(s[7:4]), hexc(s[3:0]),
                      `MLM_CH_CR, `MLM_CH_LF};
        else
            line_q = {line_q, c[7:0], c[15:8]};
    endfunction
    // Send a frame one unit per cycle; binary frames end with a pulse
    task automatic send(input logic asc, input logic [7:0] p[$],
                        input logic bad);
        frame(asc, p);
        if (bad)
            line_q[line_q.size() - 1] ^= 8'h01;
        got_q = {};
        foreach (line_q[i]) begin
            @(posedge i_sys_clk);
            o_rx_data <= line_q[i];
            o_rx_valid <= 1'b1;
        end
        @(posedge i_sys_clk);
        o_rx_valid <= 1'b0;
        o_rx_data <= ~o_rx_data; // Released line shows the inverse
        o_rx_eof <= !asc;
        @(posedge i_sys_clk);
        o_rx_eof <= 1'b0;
    endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the serial slave and link loss monitor
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SEC = 10; // Cycles per second, shortened
    typedef struct packed {
        logic asc;
        logic [7:0] fc;
        logic [15:0] val;
        logic [15:0] exp;
    } mlm_row_t;
    // Write rows pick a source, read rows expect its value
    mlm_row_t rows [10] = '{
        '{1'b0, 8'h06, 16'h0001, 16'h0001},
        '{1'b0, 8'h04, 16'h0001, 16'h00fa},
        '{1'b1, 8'h04, 16'h0001, 16'h00fa},
        '{1'b1, 8'h06, 16'h0002, 16'h0002},
        '{1'b0, 8'h04, 16'h0001, 16'h0123},
        '{1'b0, 8'h06, 16'h0003, 16'h0003},
        '{1'b1, 8'h04, 16'h0001, 16'h0ccc},
        '{1'b1, 8'h06, 16'h0004, 16'h0004},
        '{1'b0, 8'h04, 16'h0001, 16'ha5a5},
        '{1'b1, 8'h06, 16'h0005, 16'h0005}
    };
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_ascii_mode = 1'b0;
    logic i_serial_mode = 1'b0;
    logic stall = 1'b0;
    logic i_rx_valid, i_rx_eof, i_tx_ready, o_tx_valid, rd, halt_seen;
    logic [7:0] i_slave_addr = 8'h01;
    logic [7:0] i_rx_data, o_tx_data;
    logic [1:0] i_alarm_action = 2'h0; // Off while idle
    logic [9:0] i_mon_time_s = 10'h005;
    logic [15:0] i_ambient_temp = 16'h00fa;
    logic [15:0] i_ext_tune_temp = 16'h0123;
    logic [15:0] i_ch1_inlet_temp = 16'h0ccc;
    logic [15:0] i_maint_notice = 16'ha5a5;
    logic [15:0] i_hp_pressure = 16'hf334;
    logic [15:0] o_display_source_select, o_first_display_value;
    logic o_link_loss_alarm, o_warn_keep_running, o_fault_halt;
    logic [7:0] p[$], e[$], x[$]; // Request, reply payload, reply frame
    int num_errors = 0;
    int tests_run = 0;
    mlm_top #(.P_SEC_CYC(SEC)) DUT (
        .i_sys_clk, .i_rst, .i_ascii_mode, .i_slave_addr, .i_rx_data,
        .i_rx_valid, .i_rx_eof, .o_tx_data, .o_tx_valid, .i_tx_ready,
        .i_serial_mode, .i_alarm_action, .i_mon_time_s, .i_ambient_temp,
        .i_ext_tune_temp, .i_ch1_inlet_temp, .i_maint_notice,
        .i_hp_pressure, .o_display_source_select, .o_first_display_value,
        .o_link_loss_alarm, .o_warn_keep_running, .o_fault_halt
    );
    mlm_host host (
        .i_sys_clk, .i_stall(stall), .i_tx_data(o_tx_data),
        .i_tx_valid(o_tx_valid), .o_rx_data(i_rx_data),
        .o_rx_valid(i_rx_valid), .o_rx_eof(i_rx_eof), .o_tx_ready(i_tx_ready)
    );
    always #5 i_sys_clk = ~i_sys_clk;
    // Compare one value and count the result
    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Print the counts and the verdict, then stop
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Wait n edges, then let their updates settle
    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    // Send p and compare the whole reply against frame of e
    task automatic xact(input logic asc, input logic bad);
        @(posedge i_sys_clk);
        i_ascii_mode <= asc;
        x = {};
        if (e.size() > 0)
            host.frame(asc, e);
        if (e.size() > 0)
            x = host.line_q;
        host.send(asc, p, bad);
        for (int i = 0; i < 400 && host.got_q.size() < x.size(); i++)
            tick(1);
        tick(12);
        check("reply length", 16'(x.size()), 16'(host.got_q.size()));
        if (host.got_q.size() < x.size())
            close_out();
        foreach (x[i])
            check("reply unit", x[i], host.got_q[i]);
    endtask
    // Expect quiet for lo seconds, then the alarm before hi seconds
    task automatic wait_alarm(input int lo, input int hi);
        halt_seen = 1'b0;
        tick(lo * SEC);
        check("alarm early", 16'h0, o_link_loss_alarm);
        for (int i = 0; i < (hi - lo) * SEC && !o_link_loss_alarm; i++) begin
            tick(1);
            halt_seen = halt_seen | o_fault_halt;
        end
        check("alarm", 16'h1, o_link_loss_alarm);
        if (!o_link_loss_alarm)
            close_out();
    endtask
    initial begin
        repeat (8) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        tick(1);
        check("select reset", 16'h0, o_display_source_select);
        check("alarm reset", 16'h0, o_link_loss_alarm);
        foreach (rows[r]) begin
            rd = rows[r].fc == 8'h04;
            p = {8'h01, rows[r].fc, 8'h00, rd ? 8'h38 : 8'h43,
                 rows[r].val[15:8], rows[r].val[7:0]};
            e = {8'h01, 8'h04, 8'h02, rows[r].exp[15:8], rows[r].exp[7:0]};
            if (!rd)
                e = p;
            xact(rows[r].asc, 1'b0);
            if (rd)
                check("display", rows[r].exp, o_first_display_value);
            else
                check("select", rows[r].exp, o_display_source_select);
        end
        p = {8'h02, 8'h06, 8'h00, 8'h43, 8'h00, 8'h01};
        e = {};
        xact(1'b0, 1'b0);
        p[0] = 8'h01;
        xact(1'b0, 1'b1);
        check("select kept", 16'h5, o_display_source_select);
        @(posedge i_sys_clk);
        stall <= 1'b1;
        e = p;
        xact(1'b1, 1'b0);
        xact(1'b0, 1'b0);
        @(posedge i_sys_clk);
        stall <= 1'b0;
        i_serial_mode <= 1'b1;
        i_alarm_action <= 2'h1;
        xact(1'b0, 1'b0);
        wait_alarm(26, 33);
        check("warn", 16'h1, o_warn_keep_running);
        e = {};
        xact(1'b0, 1'b1);
        check("alarm kept", 16'h1, o_link_loss_alarm);
        e = p;
        xact(1'b0, 1'b0);
        check("alarm cleared", 16'h0, o_link_loss_alarm);
        @(posedge i_sys_clk);
        i_alarm_action <= 2'h2;
        xact(1'b1, 1'b0);
        wait_alarm(26, 33);
        check("halt pulse", 16'h1, halt_seen);
        check("no warn", 16'h0, o_warn_keep_running);
        @(posedge i_sys_clk);
        i_serial_mode <= 1'b0;
        tick(40 * SEC);
        check("mode off", 16'h0, o_link_loss_alarm);
        @(posedge i_sys_clk);
        i_serial_mode <= 1'b1;
        i_alarm_action <= 2'h0;
        tick(40 * SEC);
        check("action off", 16'h0, o_link_loss_alarm);
        @(posedge i_sys_clk);
        i_alarm_action <= 2'h1;
        i_mon_time_s <= 10'h2bc;
        xact(1'b0, 1'b0);
        wait_alarm(595, 603);
        @(posedge i_sys_clk);
        i_rst <= 1'b1;
        tick(2);
        check("select reset", 16'h0, o_display_source_select);
        check("alarm reset", 16'h0, o_link_loss_alarm);
        close_out();
    end
endmodule
